// ==== rtl/cbu_consts.svh ====
`ifndef CBU_CONSTS_SVH
`define CBU_CONSTS_SVH

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define CBU_FLAG_C 3'h0
`define CBU_FLAG_Z 3'h1
`define CBU_FLAG_N 3'h2
`define CBU_FLAG_V 3'h3
`define CBU_FLAG_S 3'h4
`define CBU_FLAG_H 3'h5
`define CBU_FLAG_T 3'h6
`define CBU_FLAG_I 3'h7

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define CBU_PC_W 16
`define CBU_DISP_W 7
`define CBU_PC_RST 16'h0000
`define CBU_STATUS_RST 8'h00

// ----------------------------------------
// timing, in clock cycles
// ----------------------------------------
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN 2'h2

`endif

// ==== rtl/cbu_pkg.sv ====
package cbu_pkg;

	// ----------------------------------------
	// branch operation codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		branch_on_status_bit_clear = 4'h0,
		branch_when_zero_set = 4'h1,
		branch_when_zero_clear = 4'h2,
		branch_when_carry_set = 4'h3,
		branch_when_carry_clear = 4'h4,
		branch_unsigned_ge = 4'h5,
		branch_unsigned_lt = 4'h6,
		branch_when_negative = 4'h7,
		branch_when_nonnegative = 4'h8,
		branch_signed_ge = 4'h9
	} cbu_op_t;

	// ----------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		CBU_ST_EXEC = 2'h1,
		CBU_ST_FLUSH = 2'h2
	} cbu_state_t;

endpackage

// ==== rtl/cbu_cond_eval.sv ====
`timescale 1ns/10ps
`include "cbu_consts.svh"

module cbu_cond_eval
	import cbu_pkg::*;
(
	// ----------------------------------------
	// decoded instruction and flags
	// ----------------------------------------
	input wire cbu_op_t op_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [7:0] status_in,
	// ----------------------------------------
	// result
	// ----------------------------------------
	output logic cond_out,
	output logic legal_out
);

	logic flag_c;
	logic flag_z;
	logic flag_n;
	logic flag_v;

	assign flag_c = status_in[`CBU_FLAG_C];
	assign flag_z = status_in[`CBU_FLAG_Z];
	assign flag_n = status_in[`CBU_FLAG_N];
	assign flag_v = status_in[`CBU_FLAG_V];

	always_comb begin
		cond_out = 1'b0;
		legal_out = 1'b1;
		case (op_in)
			branch_on_status_bit_clear: begin
				cond_out = ~status_in[bit_sel_in];
			end
			branch_when_zero_set: begin
				cond_out = flag_z;
			end
			branch_when_zero_clear: begin
				cond_out = ~flag_z;
			end
			branch_when_carry_set: begin
				cond_out = flag_c;
			end
			branch_when_carry_clear: begin
				cond_out = ~flag_c;
			end
			branch_unsigned_ge: begin
				cond_out = ~flag_c;
			end
			branch_unsigned_lt: begin
				cond_out = flag_c;
			end
			branch_when_negative: begin
				cond_out = flag_n;
			end
			branch_when_nonnegative: begin
				cond_out = ~flag_n;
			end
			branch_signed_ge: begin
				cond_out = ~(flag_n ^ flag_v);
			end
			default: begin
				legal_out = 1'b0;
			end
		endcase
	end

endmodule

// ==== rtl/cbu_branch_unit.sv ====
`timescale 1ns/10ps
`include "cbu_consts.svh"

module cbu_branch_unit
	import cbu_pkg::*;
#(
	parameter int PC_W = `CBU_PC_W,
	parameter int DISP_W = `CBU_DISP_W
) (
	// ----------------------------------------
	// clock and reset
	// ----------------------------------------
	input wire logic clk_in,
	input wire logic arst_n_in,
	// ----------------------------------------
	// decoded branch request
	// ----------------------------------------
	input wire logic exec_valid_in,
	input wire cbu_op_t op_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [DISP_W-1:0] disp_in,
	input wire logic [PC_W-1:0] pc_in,
	// ----------------------------------------
	// status register from the core
	// ----------------------------------------
	input wire logic [7:0] status_in,
	// ----------------------------------------
	// program counter result
	// ----------------------------------------
	output logic [PC_W-1:0] next_pc_out,
	output logic pc_load_out,
	output logic taken_out,
	// ----------------------------------------
	// pipeline timing
	// ----------------------------------------
	output logic flush_out,
	output logic busy_out,
	output logic done_out,
	output logic illegal_out,
	// ----------------------------------------
	// status register back to the core
	// ----------------------------------------
	output logic [7:0] status_out
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		cbu_state_t state;
		logic [PC_W-1:0] pc;
		logic pc_load;
		logic taken;
		logic flush;
		logic busy;
		logic done;
		logic illegal;
		logic [7:0] status;
	} cbu_regs_t;

	cbu_regs_t r;
	cbu_regs_t next_r;

	logic cond;
	logic legal;
	logic accept;
	logic take;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// relative target: pc + sign-extended offset + 1, wraps at PC_W
	function automatic logic [PC_W-1:0] rel_target(
		input logic [PC_W-1:0] pc,
		input logic [DISP_W-1:0] disp
	);
		logic [PC_W-1:0] ext;
		ext = {{(PC_W-DISP_W){disp[DISP_W-1]}}, disp};
		rel_target = pc + ext + {{(PC_W-1){1'b0}}, 1'b1};
	endfunction

	// ----------------------------------------
	// condition evaluation
	// ----------------------------------------
	cbu_cond_eval u_cond (
		.op_in(op_in),
		.bit_sel_in(bit_sel_in),
		.status_in(status_in),
		.cond_out(cond),
		.legal_out(legal)
	);

	// requests during the discard cycle are ignored
	assign accept = exec_valid_in && (r.state == CBU_ST_EXEC);
	assign take = accept && legal && cond;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.pc_load = 1'b0;
		next_r.taken = 1'b0;
		next_r.flush = 1'b0;
		next_r.done = 1'b0;
		next_r.illegal = 1'b0;
		// flags are only ever copied, never modified
		next_r.status = status_in;
		case (r.state)
			CBU_ST_EXEC: begin
				next_r.busy = 1'b0;
				if (accept) begin
					next_r.pc_load = 1'b1;
					if (take) begin
						next_r.pc = rel_target(pc_in, disp_in);
						next_r.taken = 1'b1;
						// extra cycle kills the prefetched word
						next_r.flush = 1'b1;
						next_r.busy = 1'b1;
						next_r.state = CBU_ST_FLUSH;
					end else begin
						// fall through to the next instruction
						next_r.pc = rel_target(pc_in, '0);
						next_r.done = 1'b1;
						next_r.illegal = ~legal;
					end
				end
			end
			CBU_ST_FLUSH: begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.state = CBU_ST_EXEC;
			end
			default: begin
				next_r.busy = 1'b0;
				next_r.state = CBU_ST_EXEC;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r.state <= CBU_ST_EXEC;
			r.pc <= PC_W'(`CBU_PC_RST);
			r.pc_load <= 1'b0;
			r.taken <= 1'b0;
			r.flush <= 1'b0;
			r.busy <= 1'b0;
			r.done <= 1'b0;
			r.illegal <= 1'b0;
			r.status <= `CBU_STATUS_RST;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign next_pc_out = r.pc;
	assign pc_load_out = r.pc_load;
	assign taken_out = r.taken;
	assign flush_out = r.flush;
	assign busy_out = r.busy;
	assign done_out = r.done;
	assign illegal_out = r.illegal;
	assign status_out = r.status;

endmodule

// ==== verification/cbu_branch_unit_checker.sv ====
`timescale 1ns/10ps

module cbu_branch_unit_checker
	import cbu_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int DISP_W = 7
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic exec_valid_in,
	input wire cbu_op_t op_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [DISP_W-1:0] disp_in,
	input wire logic [PC_W-1:0] pc_in,
	input wire logic [7:0] status_in,
	input wire logic [PC_W-1:0] next_pc_out,
	input wire logic pc_load_out,
	input wire logic taken_out,
	input wire logic flush_out,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic [7:0] status_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire logic acc = exec_valid_in && !busy_out;
	wire logic [7:0] s = status_in;
	AST_BSC: assert property (acc && op_in == branch_on_status_bit_clear
		|=> taken_out == !$past(s[bit_sel_in])) else $error("bit clear");
	AST_ZS: assert property (acc && op_in == branch_when_zero_set
		|=> taken_out == $past(s[1])) else $error("zero set");
	AST_ZC: assert property (acc && op_in == branch_when_zero_clear
		|=> taken_out == !$past(s[1])) else $error("zero clear");
	AST_CSET: assert property (acc && op_in == branch_when_carry_set
		|=> taken_out == $past(s[0])) else $error("carry set op");
	AST_CCLR: assert property (acc && op_in == branch_when_carry_clear
		|=> taken_out == !$past(s[0])) else $error("carry clear op");
	AST_CS: assert property (acc && op_in == branch_unsigned_lt
		|=> taken_out == $past(s[0])) else $error("unsigned lower");
	AST_CC: assert property (acc && op_in == branch_unsigned_ge
		|=> taken_out == !$past(s[0])) else $error("unsigned ge");
	AST_NEG: assert property (acc && op_in == branch_when_negative
		|=> taken_out == $past(s[2])) else $error("negative");
	AST_POS: assert property (acc && op_in == branch_when_nonnegative
		|=> taken_out == !$past(s[2])) else $error("nonnegative");
	AST_SGE: assert property (acc && op_in == branch_signed_ge
		|=> taken_out == !$past(s[2] ^ s[3])) else $error("signed ge");
	AST_PC: assert property (acc |=> pc_load_out && next_pc_out ==
		$past(pc_in) + 1'b1 + (taken_out ? {{(PC_W-DISP_W){$past(
		disp_in[DISP_W-1])}}, $past(disp_in)} : '0)) else $error("pc");
	AST_ST: assert property ($past(arst_n_in) |->
		status_out == $past(status_in)) else $error("status");
	AST_TIM: assert property (taken_out |-> flush_out && busy_out
		##1 done_out && !busy_out) else $error("taken timing");
	AST_REF: assert property (busy_out |=> !pc_load_out)
		else $error("busy load");
	cover property (acc ##1 taken_out);
	cover property (acc ##1 acc);
	cover property (busy_out && exec_valid_in);
endmodule

bind cbu_branch_unit cbu_branch_unit_checker #(.PC_W(PC_W),
	.DISP_W(DISP_W)) chk_i (.clk_in, .arst_n_in, .exec_valid_in, .op_in,
	.bit_sel_in, .disp_in, .pc_in, .status_in, .next_pc_out, .pc_load_out,
	.taken_out, .flush_out, .busy_out, .done_out, .status_out);

// ==== verification/cbu_branch_unit_bench.sv ====
`timescale 1ns/10ps

module cbu_branch_unit_bench
	import cbu_pkg::*;
;
	logic clk_in = 0, arst_n_in = 0, exec_valid_in = 0;
	cbu_op_t op_in = branch_when_zero_set;
	logic [2:0] bit_sel_in = 0;
	logic [6:0] disp_in = 0;
	logic [15:0] pc_in = 0, next_pc_out;
	logic [7:0] status_in = 0, status_out;
	logic pc_load_out, taken_out, flush_out, busy_out, done_out, illegal_out;
	int mismatches = 0, check_count = 0;
	logic [7:0] tv [10] = '{8'hf7, 8'h02, 8'hfd, 8'h01, 8'hfe, 8'hfe,
		8'h01, 8'h04, 8'hfb, 8'h0c};

	cbu_branch_unit #(.PC_W(16), .DISP_W(7)) cbu_branch_unit_inst (.clk_in,
		.arst_n_in, .exec_valid_in, .op_in, .bit_sel_in, .disp_in, .pc_in,
		.status_in, .next_pc_out, .pc_load_out, .taken_out, .flush_out,
		.busy_out, .done_out, .illegal_out, .status_out);

	initial begin
		forever #5 clk_in = ~clk_in;
	end

	task automatic end_sim;
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] w);
		check_count++;
		if (g !== w) begin
			$display("mismatch %0t %h %h", $time, g, w);
			mismatches++;
		end
	endtask

	// one request, outputs judged one edge later
	task automatic issue(input cbu_op_t o, input logic [6:0] d,
		input logic [7:0] s, input logic t);
		logic [15:0] e;
		@(posedge clk_in);
		e = pc_in + 16'h0001 + (t ? {{9{d[6]}}, d} : 16'h0000);
		exec_valid_in <= 1; op_in <= o; bit_sel_in <= 3'h3;
		disp_in <= d; status_in <= s;
		@(posedge clk_in);
		exec_valid_in <= 0;
		#1;
		chk(next_pc_out, e);
		chk(taken_out, t);
		chk(flush_out, t);
		chk(done_out, !t);
		chk(status_out, s);
		chk(illegal_out, o > 4'h9);
		if (t) begin
			@(posedge clk_in);
			#1;
			chk(done_out, 1);
			chk(busy_out, 0);
		end
	endtask

	// every kind, condition true then false
	task automatic all_kinds;
		pc_in <= 16'h1000;
		for (int i = 0; i < 10; i++) begin
			issue(cbu_op_t'(i), 7'h40, tv[i], 1);
			issue(cbu_op_t'(i), 7'h40, i == 9 ? 8'h08 : ~tv[i], 0);
		end
		issue(cbu_op_t'(4'hf), 7'h40, 8'hff, 0);
	endtask

	// wrap at top of address space
	task automatic wrap;
		pc_in <= 16'hffff;
		issue(branch_when_zero_set, 7'h3f, 8'h02, 1);
	endtask

	// back to back, then a request during the discard cycle
	task automatic b2b;
		@(posedge clk_in);
		exec_valid_in <= 1; op_in <= branch_when_zero_set; status_in <= 0;
		@(posedge clk_in);
		op_in <= branch_when_zero_clear;
		#1 chk(done_out, 1);
		@(posedge clk_in);
		op_in <= branch_when_carry_set;
		#1 chk(busy_out, 1);
		@(posedge clk_in);
		exec_valid_in <= 0;
		#1 chk(pc_load_out, 0);
		chk(next_pc_out, pc_in + 16'h0001 + {{9{disp_in[6]}}, disp_in});
		@(posedge clk_in);
		#1 chk(pc_load_out, 0);
	endtask

	initial begin
		#5000;
		mismatches++;
		end_sim;
	end

	initial begin
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1;
		all_kinds;
		wrap;
		b2b;
		end_sim;
	end
endmodule
